/* File: rfim_top.sv */
// Interrupt mask stage for regulator fault events
//
// Summary of operation
// [R1] Mask bit one keeps pin high for fault
// [R2] Mask bit zero lets fault pull pin low
// [R3] First mask: linear overvolt 7..4, undervolt 3..0
// [R4] Second mask: bit7 stepup, bit6 stepdown overvolt
// [R5] Second mask: bit5 stepup, bit4 stepdown undervolt
// [R6] Second mask: bits 3..0 linear overcurrent
// [R7] Overcurrent status reads live condition per regulator
// [R8] Masking touches only the pin, status unaffected
`timescale 1ns/1ps
`include "rfim_regs.svh"
module rfim_top
   import rfim_pkg::*;
(
   input wire logic core_clk,                 // System clock, 40 MHz
   input wire logic reset_n,                  // Asynchronous reset, active low
   input wire logic [7:0] reg_addr,           // Register offset
   input wire logic reg_wr,                   // Write strobe, one cycle
   input wire logic [7:0] reg_wdata,          // Write data
   input wire logic reg_rd,                   // Read strobe, one cycle
   output logic [7:0] reg_rdata,              // Read data, held until next read
   input wire logic [3:0] lin_overvolt_in,    // Linear regulators 4..1 overvoltage
   input wire logic [3:0] lin_undervolt_in,   // Linear regulators 4..1 undervoltage
   input wire logic [3:0] lin_overcurrent_in, // Linear regulators 4..1 overcurrent
   input wire logic stepup_overvolt_in,       // Step-up converter overvoltage
   input wire logic stepdown_overvolt_in,     // Step-down converter overvoltage
   input wire logic stepup_undervolt_in,      // Step-up converter undervoltage
   input wire logic stepdown_undervolt_in,    // Step-down converter undervoltage
   output logic fault_irq_out_n,              // Interrupt pin level, active low
   output logic fault_irq_oe                  // Interrupt pin pull-down enable
);

   // ****************************************************************
   // Fault synchronisation
   // ****************************************************************
   logic [15:0] fault_raw;    // Fault pins in mask register order
   logic [15:0] fault_sync;   // Same, settled in the clock domain
   logic [3:0] lin_ov;        // Settled linear overvoltage levels
   logic [3:0] lin_uv;        // Settled linear undervoltage levels
   logic [3:0] lin_oc;        // Settled linear overcurrent levels
   logic [3:0] conv_flt;      // Settled converter faults, stepup ov, stepdown ov, stepup uv, stepdown uv

   // Pack the pins in the layout of the two mask registers
   assign fault_raw = {lin_overvolt_in, lin_undervolt_in,
                       stepup_overvolt_in, stepdown_overvolt_in,
                       stepup_undervolt_in, stepdown_undervolt_in,
                       lin_overcurrent_in};

   // Two flops before any logic sees a comparator
   rfim_sync2 u_sync
   (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in (fault_raw),
      .sync_out (fault_sync)
   );

   // Split the settled vector back into groups
   assign lin_ov = fault_sync[15:12];
   assign lin_uv = fault_sync[11:8];
   assign conv_flt = fault_sync[7:4];
   assign lin_oc = fault_sync[3:0];

   // ****************************************************************
   // State and masking terms
   // ****************************************************************
   rfim_state_t st;          // Present state
   rfim_state_t next_st;     // Next state
   logic [7:0] volt_ev;      // Voltage mask layout events
   logic [7:0] conv_ev;      // Converter and current mask layout events
   logic [7:0] volt_pend;    // Unmasked voltage events
   logic [7:0] conv_pend;    // Unmasked converter and current events
   logic any_pend;           // Some unmasked event is active

   // Place each fault on its mask bit
   always_comb
   begin
      volt_ev = 8'h00;
      conv_ev = 8'h00;
      volt_ev[`RFIM_LIN_OV_MSB:`RFIM_LIN_OV_LSB] = lin_ov;          // see [R3]
      volt_ev[`RFIM_LIN_UV_MSB:`RFIM_LIN_UV_LSB] = lin_uv;          // see [R3]
      conv_ev[`RFIM_STEPUP_OV_BIT] = conv_flt[3];                   // see [R4]
      conv_ev[`RFIM_STEPDOWN_OV_BIT] = conv_flt[2];                 // see [R4]
      conv_ev[`RFIM_STEPUP_UV_BIT] = conv_flt[1];                   // see [R5]
      conv_ev[`RFIM_STEPDOWN_UV_BIT] = conv_flt[0];                 // see [R5]
      conv_ev[`RFIM_LIN_OC_MSB:`RFIM_LIN_OC_LSB] = lin_oc;          // see [R6]
   end

   // A set mask bit blocks its event, a clear one passes it
   assign volt_pend = volt_ev & ~st.volt_mask;   // see [R1]
   assign conv_pend = conv_ev & ~st.conv_mask;   // see [R2]
   assign any_pend = (|volt_pend) | (|conv_pend);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      next_st = st;
      // Mask writes; other offsets are read-only or absent
      if (reg_wr)
      begin
         case (reg_addr)
            `RFIM_VOLT_MASK_OFS:
            begin
               next_st.volt_mask = reg_wdata;
            end
            `RFIM_CONV_MASK_OFS:
            begin
               next_st.conv_mask = reg_wdata;
            end
            default:
            begin
               next_st.volt_mask = st.volt_mask;
            end
         endcase
      end
      // Reads capture live status whatever the masks are
      if (reg_rd)
      begin
         case (reg_addr)
            `RFIM_VOLT_STAT_OFS:
            begin
               next_st.rdata = volt_ev;                   // see [R8]
            end
            `RFIM_CURR_STAT_OFS:
            begin
               next_st.rdata = conv_ev;                   // see [R7]
            end
            `RFIM_VOLT_MASK_OFS:
            begin
               next_st.rdata = st.volt_mask;
            end
            `RFIM_CONV_MASK_OFS:
            begin
               next_st.rdata = st.conv_mask;
            end
            default:
            begin
               next_st.rdata = `RFIM_UNMAPPED_RDATA;
            end
         endcase
      end
      // Pin pulls low only for unmasked events
      next_st.irq_n = ~any_pend;                          // see [R1]
      next_st.irq_oe = any_pend;                          // see [R2]
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= RFIM_STATE_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = st.rdata;
   assign fault_irq_out_n = st.irq_n;
   assign fault_irq_oe = st.irq_oe;

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [15:0] fault_d1;   // Settled faults one edge ago
   logic [15:0] mask_d1;    // Masks one edge ago

   // Delay copies for the pipeline checks
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fault_d1 <= 16'h0000;
         mask_d1 <= 16'h0000;
      end
      else
      begin
         fault_d1 <= {volt_ev, conv_ev};
         mask_d1 <= {st.volt_mask, st.conv_mask};
      end
   end

   // Read of a status offset taken this edge
   sequence s_read_at(logic [7:0] ofs);
      reg_rd && reg_addr == ofs;
   endsequence

   // A fully masked fault set under the present masks
   sequence s_all_masked;
      (({volt_ev, conv_ev} & ~{st.volt_mask, st.conv_mask}) == 16'h0000);
   endsequence

   a_masked_pin_high: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R1]
      s_all_masked |=> fault_irq_out_n && !fault_irq_oe)
      else $error("Pin pulled low with all active faults masked");

   a_unmasked_pin_low: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R2]
      ((fault_d1 & ~mask_d1) != 16'h0000) |-> !fault_irq_out_n && fault_irq_oe)
      else $error("Unmasked fault did not pull the pin low");

   a_lin1_ov_map: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R3]
      (lin_ov[0] && !st.volt_mask[4]) |=> !fault_irq_out_n)
      else $error("Linear 1 overvoltage not on mask bit 4");

   a_lin4_uv_map: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R3]
      (fault_sync == 16'h0800 && st.volt_mask == 8'h08) |=> fault_irq_out_n)
      else $error("Linear 4 undervoltage not blocked by mask bit 3");

   a_stepup_ov_map: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R4]
      (fault_sync == 16'h0080 && st.conv_mask == 8'h80) |=> fault_irq_out_n)
      else $error("Step-up overvoltage not blocked by mask bit 7");

   a_stepdown_uv_map: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R5]
      (fault_sync == 16'h0010 && st.conv_mask == 8'hef) |=> !fault_irq_out_n)
      else $error("Step-down undervoltage not passed with bit 4 clear");

   a_lin4_oc_map: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R6]
      (fault_sync == 16'h0008 && st.conv_mask == 8'h08) |=> fault_irq_out_n)
      else $error("Linear 4 overcurrent not blocked by mask bit 3");

   a_oc_status_read: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R7]
      s_read_at(`RFIM_CURR_STAT_OFS) |=> reg_rdata[3:0] == $past(lin_oc))
      else $error("Overcurrent status does not match the live condition");

   a_status_unmasked: assert property (@(posedge core_clk) disable iff (!reset_n) // see [R8]
      s_read_at(`RFIM_VOLT_STAT_OFS) |=> reg_rdata == $past(volt_ev))
      else $error("Voltage status altered by masking");

   a_mask_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == `RFIM_CONV_MASK_OFS) |=> st.conv_mask == $past(reg_wdata))
      else $error("Mask write not stored");

endmodule

/* File: rfim_regs.svh */
// Register offsets, field positions, reset values and pipeline figures of the fault interrupt mask stage
`ifndef RFIM_REGS_SVH
`define RFIM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RFIM_VOLT_STAT_OFS    8'h14
`define RFIM_CURR_STAT_OFS    8'h15
`define RFIM_VOLT_MASK_OFS    8'h17
`define RFIM_CONV_MASK_OFS    8'h18

// ****************************************************************
// Reset values
// ****************************************************************
`define RFIM_VOLT_MASK_RST    8'h00
`define RFIM_CONV_MASK_RST    8'h00
`define RFIM_UNMAPPED_RDATA   8'h00

// ****************************************************************
// Field positions in the voltage mask register
// ****************************************************************
`define RFIM_LIN_OV_MSB       7
`define RFIM_LIN_OV_LSB       4
`define RFIM_LIN_UV_MSB       3
`define RFIM_LIN_UV_LSB       0

// ****************************************************************
// Field positions in the converter and current mask register
// ****************************************************************
`define RFIM_STEPUP_OV_BIT    7
`define RFIM_STEPDOWN_OV_BIT  6
`define RFIM_STEPUP_UV_BIT    5
`define RFIM_STEPDOWN_UV_BIT  4
`define RFIM_LIN_OC_MSB       3
`define RFIM_LIN_OC_LSB       0

// ****************************************************************
// Timing: edges from a fault pin change to the interrupt pin
// ****************************************************************
`define RFIM_FAULT_TO_IRQ     3

`endif

/* File: rfim_pkg.sv */
// Types shared by the fault interrupt mask stage
package rfim_pkg;

   // ****************************************************************
   // State of the two-stage fault synchroniser
   // ****************************************************************
   typedef struct packed
   {
      logic [15:0] stage1;   // First capture, read only by stage2
      logic [15:0] stage2;   // Settled fault levels
   } rfim_sync_t;

   // ****************************************************************
   // State of the mask stage
   // ****************************************************************
   typedef struct packed
   {
      logic [7:0] volt_mask;   // Linear regulator voltage fault masks
      logic [7:0] conv_mask;   // Converter voltage and linear current masks
      logic [7:0] rdata;       // Read data holding register
      logic irq_n;             // Interrupt pin level, low while pulling
      logic irq_oe;            // Interrupt pin driver enable
   } rfim_state_t;

   // Reset image of the mask stage state
   localparam rfim_state_t RFIM_STATE_RST = '{
      volt_mask: 8'h00,
      conv_mask: 8'h00,
      rdata:     8'h00,
      irq_n:     1'b1,
      irq_oe:    1'b0
   };

endpackage

/* File: rfim_sync2.sv */
// Two flip-flop synchroniser for the sixteen fault comparator levels
`timescale 1ns/1ps
module rfim_sync2
   import rfim_pkg::*;
(
   input wire logic core_clk,            // System clock
   input wire logic reset_n,             // Asynchronous reset, active low
   input wire logic [15:0] async_in,     // Fault levels from the analog side
   output logic [15:0] sync_out          // Fault levels in the clock domain
);

   // ****************************************************************
   // State registers
   // ****************************************************************
   rfim_sync_t st;        // Present state
   rfim_sync_t next_st;   // Next state

   // Shift the levels one stage per edge
   always_comb
   begin
      next_st = st;
      next_st.stage1 = async_in;
      next_st.stage2 = st.stage1;
   end

   // Register the state, cleared by reset
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Only the second stage leaves the module
   assign sync_out = st.stage2;

endmodule

/* File: rfim_host_model.sv */
// Host side of the shared open-drain interrupt line
`timescale 1ns/1ps
module rfim_host_model
(
   input wire logic irq_oe,    // Device pull-down enable
   output logic irq_line_n     // Resolved line level seen by the host
);
   // ****************************************************************
   // Line resolution
   // ****************************************************************
   // Board pull-up holds the line high unless the device pulls it down
   assign irq_line_n = irq_oe ? 1'b0 : 1'b1;
endmodule

/* File: rfim_tb.sv */
// Self-checking testbench of the fault interrupt mask stage
`timescale 1ns/1ps
`include "rfim_regs.svh"
module testbench;
   // ****************************************************************
   // Stimulus and observation signals
   // ****************************************************************
   logic core_clk = 1'b0;     // System clock
   logic reset_n = 1'b0;      // Reset, active low
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] faults = 16'h0000;  // Voltage mask layout above converter layout
   logic [7:0] reg_rdata;
   logic fault_irq_out_n;
   logic fault_irq_oe;
   logic irq_line_n;          // Wire level after the pull-up
   logic rd_taken = 1'b0;     // A read strobe was taken at the last edge
   logic irq_chk = 1'b0;      // Request to sample the line
   logic irq_taken = 1'b0;
   logic [7:0] exp_q[$];      // Expected results, oldest first
   logic [15:0] f;
   logic [15:0] m;
   int num_errors = 0;
   int tests_run = 0;

   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end

   rfim_top dut
   (
      .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .lin_overvolt_in(faults[15:12]), .lin_undervolt_in(faults[11:8]),
      .stepup_overvolt_in(faults[7]), .stepdown_overvolt_in(faults[6]),
      .stepup_undervolt_in(faults[5]), .stepdown_undervolt_in(faults[4]),
      .lin_overcurrent_in(faults[3:0]),
      .fault_irq_out_n(fault_irq_out_n), .fault_irq_oe(fault_irq_oe)
   );

   rfim_host_model host
   (
      .irq_oe(fault_irq_oe),
      .irq_line_n(irq_line_n)
   );

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   // Compare one result with its note, report a mismatch
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict: no mismatch, some comparisons, no note left over
   task automatic test_done;
      if (num_errors == 0 && tests_run > 0 && exp_q.size() == 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask

   // One-cycle read strobe, result compared by the monitor
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
   endtask

   // Sample pin level and resolved line, both must equal e
   task automatic irq(input logic e);
      exp_q.push_back({6'h00, e, e});
      @(negedge core_clk);
      irq_chk = 1'b1;
      @(negedge core_clk);
      irq_chk = 1'b0;
   endtask

   // Both mask registers, voltage mask in the upper byte
   task automatic set_masks(input logic [15:0] v);
      wr(`RFIM_VOLT_MASK_OFS, v[15:8]);
      wr(`RFIM_CONV_MASK_OFS, v[7:0]);
   endtask

   // New fault levels, then let the synchroniser settle
   task automatic set_faults(input logic [15:0] v);
      @(negedge core_clk);
      faults = v;
      repeat (3) @(negedge core_clk);
   endtask

   // ****************************************************************
   // Monitor: takes the oldest note whenever a result appears
   // ****************************************************************
   always @(posedge core_clk)
   begin
      rd_taken <= reg_rd;
      irq_taken <= irq_chk;
   end

   always @(negedge core_clk)
   begin
      if (rd_taken || irq_taken)
      begin
         if (exp_q.size() == 0)
            num_errors++;
         else
            check(rd_taken ? reg_rdata : {6'h00, fault_irq_out_n, irq_line_n}, exp_q.pop_front());
      end
   end

   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      test_done();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      void'($urandom(11));
      repeat (3) @(negedge core_clk);
      irq(1'b1);
      @(negedge core_clk);
      reset_n = 1'b1;
      // Reset values, unmapped read, write to read-only status
      rd(`RFIM_VOLT_MASK_OFS, 8'h00);
      rd(`RFIM_CONV_MASK_OFS, 8'h00);
      rd(8'h20, 8'h00);
      wr(`RFIM_VOLT_STAT_OFS, 8'hff);
      rd(`RFIM_VOLT_STAT_OFS, 8'h00);
      // Masks are read/write, back to back
      repeat (4)
      begin
         m = 16'($urandom);
         set_masks(m);
         rd(`RFIM_VOLT_MASK_OFS, m[15:8]);
         rd(`RFIM_CONV_MASK_OFS, m[7:0]);
      end
      // Every fault bit: unmasked, masked alone, others masked
      for (int i = 0; i < 16; i++)
      begin
         f = 16'h0001 << i;
         set_masks(16'h0000);
         set_faults(f);
         irq(1'b0);
         rd(`RFIM_VOLT_STAT_OFS, f[15:8]);
         rd(`RFIM_CURR_STAT_OFS, f[7:0]);
         set_masks(f);
         irq(1'b1);
         rd(`RFIM_CURR_STAT_OFS, f[7:0]);
         set_masks(~f);
         irq(1'b0);
         set_faults(16'h0000);
         irq(1'b1);
      end
      // Random masks against random faults
      repeat (20)
      begin
         f = 16'($urandom);
         m = 16'($urandom);
         set_masks(m);
         set_faults(f);
         irq(~|(f & ~m));
      end
      // Reset in mid-run clears the masks, faults stay present
      set_masks(16'hffff);
      irq(1'b1);
      @(negedge core_clk);
      reset_n = 1'b0;
      @(negedge core_clk);
      reset_n = 1'b1;
      rd(`RFIM_VOLT_MASK_OFS, 8'h00);
      rd(`RFIM_CONV_MASK_OFS, 8'h00);
      // Cleared masks let the standing faults through again
      irq(~|f);
      repeat (3) @(negedge core_clk);
      test_done();
   end
endmodule
